// >>> verilog/sfb_pkg.sv
// Purpose: Shared constants for the serial channel baud fraction and FIFO configuration block
// Assumes: APB register access with 32-bit data, one aligned word per register
// Notes: Every offset, field position, config register reset value and duplex code used by the logic lives here
package sfb_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] ADDR_FRAC = 8'h00; // baud_fraction_control
	localparam logic [7:0] ADDR_FCNF = 8'h04; // fifo_config
	localparam logic [7:0] ADDR_CTRL = 8'h08; // Channel control
	localparam logic [7:0] ADDR_STAT = 8'h0C; // Channel status, read only
	localparam int ADDR_W = 8; // Decoded address bits

	// ==========================================================
	// baud_fraction_control fields
	localparam int K_LSB = 0; // Fraction K
	localparam int K_W = 4;
	localparam logic [3:0] K_RST = 4'h0;
	localparam logic [3:0] K_PROHIBITED = 4'h0; // Code that must never be used

	// ==========================================================
	// fifo_config fields
	localparam int FC_FIFO_EN = 0; // FIFO enable
	localparam int FC_AUTO_DIS = 1; // auto_disable_ctrl
	localparam int FC_RX_IRQ_EN = 2; // rx_fifo_irq_enable
	localparam int FC_TX_IRQ_EN = 3; // tx_fifo_irq_enable
	localparam int FC_RX_DEPTH_SEL = 4; // rx_fifo_depth_select
	localparam int FC_W = 5;
	localparam logic [4:0] FC_RST = 5'h00;

	// ==========================================================
	// Channel control fields
	localparam int CT_N_LSB = 0; // Integer divisor code
	localparam int CT_N_W = 4;
	localparam int CT_FRAC_EN = 4; // Fractional divide enable
	localparam int CT_FILL_LSB = 5; // Receive interrupt fill level code
	localparam int CT_FILL_W = 2;
	localparam int CT_RX_EN = 7; // Receiver enable
	localparam int CT_TX_EN = 8; // Transmitter enable
	localparam int CT_W = 9;
	localparam logic [8:0] CT_RST = 9'h000;

	// ==========================================================
	// Channel status fields
	localparam int ST_RX_DEPTH_LSB = 0; // Usable receive bytes
	localparam int ST_TX_DEPTH_LSB = 4; // Usable transmit bytes
	localparam int DEPTH_W = 3;

	// ==========================================================
	// Duplex codes from the channel mode logic
	localparam int DPX_W = 2;
	localparam logic [1:0] DPX_NONE = 2'h0;
	localparam logic [1:0] DPX_HALF_RX = 2'h1;
	localparam logic [1:0] DPX_HALF_TX = 2'h2;
	localparam logic [1:0] DPX_FULL = 2'h3;

	// ==========================================================
	// FIFO sizes and divider constants
	localparam logic [2:0] FIFO_ALL = 3'h4; // Whole FIFO to one side
	localparam logic [2:0] FIFO_SPLIT = 3'h2; // Each side in full duplex
	localparam logic [2:0] FIFO_NONE = 3'h0;
	localparam logic [2:0] BYTES_1 = 3'h1;
	localparam logic [2:0] BYTES_2 = 3'h2;
	localparam logic [2:0] BYTES_3 = 3'h3;
	localparam logic [4:0] N_ZERO_VAL = 5'h10; // Divisor code zero means sixteen
	localparam logic [4:0] FRAC_DEN = 5'h10; // Sixteenths
endpackage

// >>> verilog/sfb_cfg.sv
// Purpose: Fractional baud generator and FIFO configuration of one serial channel
// Assumes: APB slave, one clock, all channel inputs synchronous to pclk
// Notes: The shift, framing and FIFO storage logic sit outside and use the outputs
//
// Behaviour
// - Fraction field bits 3:0 hold K, zero prohibited
// - Enable off divides by N, on N+(16-K)/16
// - Fractional division only in UART mode
// - Depth select zero uses full receive allotment
// - Depth select one uses receive fill level
// - Bit 3 gates transmit FIFO interrupts
// - Bit 2 gates receive FIFO interrupts
// - Auto disable clears receiver when bytes received
// - Auto disable clears transmitter when all empty
// - Full duplex: either condition clears both enables
// - Bit 0 enables the FIFO
// - Duplex splits FIFO as 4, 4, 2+2
// - Transmit side always gets full allotment
// - Divisor code zero means N equals 16
`timescale 1ns/1ps

module sfb_cfg (
	// Clock, reset and freeze
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Channel mode and state
	input wire logic uart_mode,
	input wire logic [sfb_pkg::DPX_W-1:0] duplex_mode,
	input wire logic baud_src_tick,
	input wire logic [2:0] rx_valid_bytes,
	input wire logic tx_all_empty,
	input wire logic tx_irq_raw,
	input wire logic rx_irq_raw,
	// Channel controls
	output logic baud_tick,
	output logic fifo_enable,
	output logic [2:0] rx_fifo_depth,
	output logic [2:0] tx_fifo_depth,
	output logic rx_enable,
	output logic tx_enable,
	output logic tx_irq,
	output logic rx_irq
);
	// ==========================================================
	// Register state
	logic [sfb_pkg::K_W-1:0] frac_k_r, frac_k_nxt; // Fraction K
	logic [sfb_pkg::FC_W-1:0] fcnf_r, fcnf_nxt; // fifo_config bits
	logic [sfb_pkg::CT_W-1:0] ctrl_r, ctrl_nxt; // Channel control bits
	logic [31:0] prdata_r, prdata_nxt; // Read data
	logic pready_r, pready_nxt; // One wait state answer
	logic pslverr_r, pslverr_nxt; // Unmapped address flag

	// ==========================================================
	// Divider state
	logic [4:0] cnt_r, cnt_nxt; // Source ticks in this baud cycle
	logic [3:0] acc_r, acc_nxt; // Fraction accumulator
	logic ext_r, ext_nxt; // This cycle is one tick longer
	logic tick_r, tick_nxt; // Baud tick output

	// ==========================================================
	// Output state
	logic [2:0] rx_depth_r, rx_depth_nxt;
	logic [2:0] tx_depth_r, tx_depth_nxt;
	logic tx_irq_r, tx_irq_nxt;
	logic rx_irq_r, rx_irq_nxt;

	// ==========================================================
	// Decoded fields
	logic fifo_en; // FIFO enable
	logic auto_dis; // auto_disable_ctrl
	logic rx_depth_sel; // rx_fifo_depth_select
	logic [3:0] n_code; // Integer divisor code
	logic [4:0] n_val; // Integer divisor value
	logic frac_on; // Fractional division active
	logic [2:0] fill_bytes; // Receive fill level in bytes
	logic [2:0] rx_max; // Receive allotment by duplex
	logic [2:0] tx_max; // Transmit allotment by duplex
	logic acc_set; // Access phase at a ready edge
	logic wr_en; // Register write strobe
	logic rx_done; // Receive count reached
	logic tx_done; // Transmit side drained
	logic clr_rx; // Auto clear of receiver enable
	logic clr_tx; // Auto clear of transmitter enable

	assign fifo_en = fcnf_r[sfb_pkg::FC_FIFO_EN];
	assign auto_dis = fcnf_r[sfb_pkg::FC_AUTO_DIS];
	assign rx_depth_sel = fcnf_r[sfb_pkg::FC_RX_DEPTH_SEL];
	assign n_code = ctrl_r[sfb_pkg::CT_N_LSB +: sfb_pkg::CT_N_W];
	// Code zero stands for sixteen
	assign n_val = (n_code == '0) ? sfb_pkg::N_ZERO_VAL : {1'b0, n_code};
	// Fraction only in UART mode; a prohibited K falls back to plain N
	assign frac_on = ctrl_r[sfb_pkg::CT_FRAC_EN] && uart_mode && (frac_k_r != sfb_pkg::K_PROHIBITED);
	assign acc_set = psel && penable && pready_r;
	assign wr_en = acc_set && pwrite;

	// ==========================================================
	// Allotments by duplex and fill level mapping
	always_comb begin
		// FIFO off leaves both sides with no bytes
		rx_max = sfb_pkg::FIFO_NONE;
		tx_max = sfb_pkg::FIFO_NONE;
		if (fifo_en) begin
			unique case (duplex_mode)
				sfb_pkg::DPX_HALF_RX: begin
					rx_max = sfb_pkg::FIFO_ALL;
				end
				sfb_pkg::DPX_HALF_TX: begin
					tx_max = sfb_pkg::FIFO_ALL;
				end
				sfb_pkg::DPX_FULL: begin
					rx_max = sfb_pkg::FIFO_SPLIT;
					tx_max = sfb_pkg::FIFO_SPLIT;
				end
				sfb_pkg::DPX_NONE: begin
					rx_max = sfb_pkg::FIFO_NONE;
				end
			endcase
		end
		// Fill level code to bytes, full duplex maps codes 0 and 3 to 2 and 1 bytes
		unique case (ctrl_r[sfb_pkg::CT_FILL_LSB +: sfb_pkg::CT_FILL_W])
			2'h0: fill_bytes = (duplex_mode == sfb_pkg::DPX_FULL) ? sfb_pkg::BYTES_2 : sfb_pkg::FIFO_ALL;
			2'h1: fill_bytes = sfb_pkg::BYTES_1;
			2'h2: fill_bytes = sfb_pkg::BYTES_2;
			2'h3: fill_bytes = (duplex_mode == sfb_pkg::DPX_FULL) ? sfb_pkg::BYTES_1 : sfb_pkg::BYTES_3;
		endcase
	end

	// ==========================================================
	// Auto disable conditions
	always_comb begin
		// Count covers shift register, buffers and FIFO
		rx_done = rx_valid_bytes >= rx_depth_r;
		tx_done = tx_all_empty;
		clr_rx = 1'b0;
		clr_tx = 1'b0;
		if (auto_dis) begin
			unique case (duplex_mode)
				sfb_pkg::DPX_HALF_RX: begin
					clr_rx = rx_done && ctrl_r[sfb_pkg::CT_RX_EN];
				end
				sfb_pkg::DPX_HALF_TX: begin
					clr_tx = tx_done && ctrl_r[sfb_pkg::CT_TX_EN];
				end
				sfb_pkg::DPX_FULL: begin
					// Either side finishing stops both
					clr_rx = (rx_done && ctrl_r[sfb_pkg::CT_RX_EN]) || (tx_done && ctrl_r[sfb_pkg::CT_TX_EN]);
					clr_tx = clr_rx;
				end
				sfb_pkg::DPX_NONE: begin
					clr_rx = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// APB register file, next values
	always_comb begin
		frac_k_nxt = frac_k_r;
		fcnf_nxt = fcnf_r;
		ctrl_nxt = ctrl_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		// Ready goes high for one cycle after the first access cycle
		pready_nxt = psel && penable && !pready_r;
		if (psel && penable && !pready_r) begin
			pslverr_nxt = 1'b0;
			prdata_nxt = '0;
			// Unused bits stay zero on read
			unique case (paddr[sfb_pkg::ADDR_W-1:0])
				sfb_pkg::ADDR_FRAC: prdata_nxt[sfb_pkg::K_W-1:0] = frac_k_r;
				sfb_pkg::ADDR_FCNF: prdata_nxt[sfb_pkg::FC_W-1:0] = fcnf_r;
				sfb_pkg::ADDR_CTRL: prdata_nxt[sfb_pkg::CT_W-1:0] = ctrl_r;
				sfb_pkg::ADDR_STAT: begin
					prdata_nxt[sfb_pkg::ST_RX_DEPTH_LSB +: sfb_pkg::DEPTH_W] = rx_depth_r;
					prdata_nxt[sfb_pkg::ST_TX_DEPTH_LSB +: sfb_pkg::DEPTH_W] = tx_depth_r;
				end
				default: pslverr_nxt = 1'b1;
			endcase
			// Upper address bits must be zero too
			if (paddr[31:sfb_pkg::ADDR_W] != '0) begin
				pslverr_nxt = 1'b1;
				prdata_nxt = '0;
			end
		end
		// Writes land at the ready edge; upper bits are dropped
		if (wr_en && !pslverr_r) begin
			unique case (paddr[sfb_pkg::ADDR_W-1:0])
				sfb_pkg::ADDR_FRAC: frac_k_nxt = pwdata[sfb_pkg::K_LSB +: sfb_pkg::K_W];
				sfb_pkg::ADDR_FCNF: fcnf_nxt = pwdata[sfb_pkg::FC_W-1:0];
				sfb_pkg::ADDR_CTRL: ctrl_nxt = pwdata[sfb_pkg::CT_W-1:0];
				default: fcnf_nxt = fcnf_r;
			endcase
		end
		// Hardware clear wins over a same-cycle software set
		if (clr_rx) begin
			ctrl_nxt[sfb_pkg::CT_RX_EN] = 1'b0;
		end
		if (clr_tx) begin
			ctrl_nxt[sfb_pkg::CT_TX_EN] = 1'b0;
		end
	end

	// APB register file, flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frac_k_r <= sfb_pkg::K_RST;
			fcnf_r <= sfb_pkg::FC_RST;
			ctrl_r <= sfb_pkg::CT_RST;
			prdata_r <= '0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			frac_k_r <= frac_k_nxt;
			fcnf_r <= fcnf_nxt;
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ==========================================================
	// Baud divider, next values
	always_comb begin
		logic [4:0] sum; // Accumulator plus step
		logic [4:0] term; // Last tick index of this cycle
		sum = {1'b0, acc_r} + (sfb_pkg::FRAC_DEN - {1'b0, frac_k_r});
		term = n_val - 5'h01 + {4'h0, ext_r};
		cnt_nxt = cnt_r;
		acc_nxt = acc_r;
		ext_nxt = ext_r;
		tick_nxt = 1'b0;
		if (baud_src_tick) begin
			if (cnt_r >= term) begin
				cnt_nxt = '0;
				tick_nxt = 1'b1;
				// Overflow of a 16-step accumulator spreads 16-K long cycles evenly
				if (frac_on) begin
					acc_nxt = sum[3:0];
					ext_nxt = sum[4];
				end else begin
					// Plain N ignores the fraction field
					acc_nxt = '0;
					ext_nxt = 1'b0;
				end
			end else begin
				cnt_nxt = cnt_r + 5'h01;
			end
		end
	end

	// Baud divider, flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			acc_r <= '0;
			ext_r <= 1'b0;
			tick_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			acc_r <= acc_nxt;
			ext_r <= ext_nxt;
			tick_r <= tick_nxt;
		end
	end

	// ==========================================================
	// Depths and interrupt gating, next values
	always_comb begin
		// Depth select narrows only the receive side
		// No receive allotment (half duplex transmit, none) leaves nothing to narrow
		rx_depth_nxt = (rx_depth_sel && fifo_en && (rx_max != sfb_pkg::FIFO_NONE)) ? fill_bytes : rx_max;
		tx_depth_nxt = tx_max;
		// Without the FIFO the buffer interrupts pass ungated
		tx_irq_nxt = tx_irq_raw && (!fifo_en || fcnf_r[sfb_pkg::FC_TX_IRQ_EN]);
		rx_irq_nxt = rx_irq_raw && (!fifo_en || fcnf_r[sfb_pkg::FC_RX_IRQ_EN]);
	end

	// Depths and interrupt gating, flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_depth_r <= sfb_pkg::FIFO_NONE;
			tx_depth_r <= sfb_pkg::FIFO_NONE;
			tx_irq_r <= 1'b0;
			rx_irq_r <= 1'b0;
		end else if (ce) begin
			rx_depth_r <= rx_depth_nxt;
			tx_depth_r <= tx_depth_nxt;
			tx_irq_r <= tx_irq_nxt;
			rx_irq_r <= rx_irq_nxt;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign baud_tick = tick_r;
	assign fifo_enable = fcnf_r[sfb_pkg::FC_FIFO_EN];
	assign rx_fifo_depth = rx_depth_r;
	assign tx_fifo_depth = tx_depth_r;
	assign rx_enable = ctrl_r[sfb_pkg::CT_RX_EN];
	assign tx_enable = ctrl_r[sfb_pkg::CT_TX_EN];
	assign tx_irq = tx_irq_r;
	assign rx_irq = rx_irq_r;
endmodule

// >>> dv/sfb_cfg_asserts.sv
// Purpose: Port checks for sfb_cfg
// Assumes: ce held high
// Notes: Depth and irq outputs lag config by a cycle
`timescale 1ns/1ps
module sfb_cfg_asserts (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Channel
	input wire logic [sfb_pkg::DPX_W-1:0] duplex_mode,
	input wire logic baud_src_tick,
	input wire logic tx_irq_raw,
	input wire logic baud_tick,
	input wire logic fifo_enable,
	input wire logic [2:0] rx_fifo_depth,
	input wire logic [2:0] tx_fifo_depth,
	input wire logic rx_enable,
	input wire logic tx_irq
);
	// ====
	// One domain, so one clocking
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	bus_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	bus_cause_a: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("error read not zero");
	depth_off_a: assert property ($past(!fifo_enable) |-> rx_fifo_depth == 3'h0 && tx_fifo_depth == 3'h0)
		else $error("depth without fifo");
	tx_half_a: assert property ($past(fifo_enable && duplex_mode == sfb_pkg::DPX_HALF_TX) |-> tx_fifo_depth == 3'h4)
		else $error("tx depth half");
	tx_full_a: assert property ($past(fifo_enable && duplex_mode == sfb_pkg::DPX_FULL) |-> tx_fifo_depth == 3'h2)
		else $error("tx depth full");
	irq_cause_a: assert property (tx_irq |-> $past(tx_irq_raw))
		else $error("tx irq without cause");
	irq_pass_a: assert property ($past(!fifo_enable) |-> tx_irq == $past(tx_irq_raw))
		else $error("tx irq not passed");
	tick_cause_a: assert property (baud_tick |-> $past(baud_src_tick))
		else $error("baud tick without source");
	rx_set_a: assert property ($rose(rx_enable) |-> $past(pready && pwrite))
		else $error("rx enable set by itself");
endmodule
bind sfb_cfg sfb_cfg_asserts u_sfb_cfg_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .duplex_mode(duplex_mode),
	.baud_src_tick(baud_src_tick), .tx_irq_raw(tx_irq_raw), .baud_tick(baud_tick), .fifo_enable(fifo_enable),
	.rx_fifo_depth(rx_fifo_depth), .tx_fifo_depth(tx_fifo_depth), .rx_enable(rx_enable), .tx_irq(tx_irq));

// >>> dv/sfb_peer.sv
// Purpose: Far side of the channel: source ticks and fill state
// Assumes: One pclk domain
// Notes: Gap of 2 keeps ticks off the baud tick edge
`timescale 1ns/1ps
module sfb_peer #(parameter int TICK_GAP = 2) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Towards the channel
	output logic baud_src_tick,
	output logic [2:0] rx_valid_bytes,
	output logic tx_all_empty
);
	int gap_cnt; // Cycles since last tick
	initial begin
		rx_valid_bytes = 3'h0;
		tx_all_empty = 1'h0;
	end
	// ====
	// Source tick, one pulse each gap
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cnt <= 0;
			baud_src_tick <= 1'h0;
		end else begin
			gap_cnt <= (gap_cnt + 1) % TICK_GAP;
			baud_src_tick <= (gap_cnt == 0);
		end
	end
	// Fill state moves only at an edge
	task automatic set_fill(input logic [2:0] nbytes, input logic empty);
		@(posedge pclk);
		rx_valid_bytes <= nbytes;
		tx_all_empty <= empty;
	endtask
endmodule

// >>> dv/sfb_cfg_tb_top.sv
// Purpose: Self-checking bench for sfb_cfg
// Assumes: ce tied high, tasks start right after an edge
// Notes: Peer gives ticks and fill state
`timescale 1ns/1ps
module sfb_cfg_tb_top;
	// ====
	// Signals
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic uart_mode = 1'h1;
	logic [1:0] duplex_mode = 2'h0;
	logic tx_irq_raw = 1'h0;
	logic rx_irq_raw = 1'h0;
	logic [31:0] prdata;
	logic pready, pslverr, baud_src_tick, tx_all_empty, baud_tick, fifo_enable;
	logic [2:0] rx_valid_bytes, rx_fifo_depth, tx_fifo_depth;
	logic rx_enable, tx_enable, tx_irq, rx_irq;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	// Divider table: N, K, frac, uart, periods, source ticks
	int dv[5][6] = '{'{3, 4, 0, 1, 16, 48}, '{3, 4, 1, 1, 16, 60}, '{3, 4, 1, 0, 16, 48},
		'{0, 4, 0, 1, 2, 32}, '{2, 15, 1, 1, 16, 33}};
	always #4 pclk = ~pclk;
	sfb_cfg u_sfb_cfg (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.uart_mode(uart_mode), .duplex_mode(duplex_mode), .baud_src_tick(baud_src_tick),
		.rx_valid_bytes(rx_valid_bytes), .tx_all_empty(tx_all_empty), .tx_irq_raw(tx_irq_raw),
		.rx_irq_raw(rx_irq_raw), .baud_tick(baud_tick), .fifo_enable(fifo_enable),
		.rx_fifo_depth(rx_fifo_depth), .tx_fifo_depth(tx_fifo_depth), .rx_enable(rx_enable),
		.tx_enable(tx_enable), .tx_irq(tx_irq), .rx_irq(rx_irq));
	sfb_peer u_sfb_peer (.pclk(pclk), .presetn(presetn), .baud_src_tick(baud_src_tick),
		.rx_valid_bytes(rx_valid_bytes), .tx_all_empty(tx_all_empty));
	// ====
	// Tasks
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// APB transfer, held until pready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge: the next call never reassigns psel in this step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		bus(1'h1, a, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] r;
		logic e;
		bus(1'h0, a, 32'h0, r, e);
		chk(nm, exp, r);
	endtask
	// Source ticks over whole divider periods
	task automatic meas(input int per, input int exp);
		int t = 0;
		int b = 0;
		repeat (2) @(posedge pclk iff baud_tick === 1'h1);
		while (b < per) begin
			@(posedge pclk);
			t += (baud_src_tick === 1'h1);
			b += (baud_tick === 1'h1);
		end
		chk("divide", exp, t);
	endtask
	// Expected status word
	function automatic logic [31:0] exp_stat(logic [1:0] d, logic s, logic [1:0] f);
		logic [2:0] rx;
		logic [2:0] tx;
		rx = (d == sfb_pkg::DPX_HALF_RX) ? 3'h4 : (d == sfb_pkg::DPX_FULL) ? 3'h2 : 3'h0;
		tx = (d == sfb_pkg::DPX_HALF_TX) ? 3'h4 : (d == sfb_pkg::DPX_FULL) ? 3'h2 : 3'h0;
		if (s && d == sfb_pkg::DPX_HALF_RX) rx = (f == 2'h0) ? 3'h4 : {1'h0, f};
		if (s && d == sfb_pkg::DPX_FULL) rx = f[0] ? 3'h1 : 3'h2;
		return {25'h0, tx, 1'h0, rx};
	endfunction
	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	// ====
	// Tests
	initial begin
		logic [31:0] r;
		logic e;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		for (int i = 0; i < 16; i += 4) begin
			rd(i[7:0], 32'h0, "reset");
		end
		bus(1'h0, 8'h10, 32'h0, r, e);
		chk("unmapped", 32'h1, {31'h0, e});
		wr(sfb_pkg::ADDR_FRAC, 32'hFFFFFFF5);
		rd(sfb_pkg::ADDR_FRAC, 32'h5, "frac");
		wr(sfb_pkg::ADDR_FCNF, 32'hFFFFFFE0);
		rd(sfb_pkg::ADDR_FCNF, 32'h0, "fcnf");
		$display("test regs done");
		for (int i = 0; i < 32; i++) begin
			duplex_mode <= i[4:3];
			wr(sfb_pkg::ADDR_CTRL, {25'h0, i[1:0], 5'h02});
			wr(sfb_pkg::ADDR_FCNF, {27'h0, i[2], 4'h1});
			rd(sfb_pkg::ADDR_STAT, exp_stat(i[4:3], i[2], i[1:0]), "depth");
		end
		$display("test depth done");
		for (int i = 0; i < 5; i++) begin
			uart_mode <= dv[i][3][0];
			wr(sfb_pkg::ADDR_FRAC, dv[i][1]);
			wr(sfb_pkg::ADDR_CTRL, dv[i][0] | (dv[i][2] << 4));
			meas(dv[i][4], dv[i][5]);
		end
		$display("test divider done");
		wr(sfb_pkg::ADDR_FCNF, 32'h3);
		for (int i = 0; i < 6; i++) begin
			u_sfb_peer.set_fill(3'h0, 1'h0);
			duplex_mode <= 2'(i / 2 + 1);
			wr(sfb_pkg::ADDR_CTRL, 32'h182);
			chk("armed", 32'h3, {30'h0, rx_enable, tx_enable});
			u_sfb_peer.set_fill(i[0] ? 3'h0 : 3'h4, i[0]);
			repeat (3) @(posedge pclk);
			chk("auto", (i > 3) ? 0 : (i == 0) ? 1 : (i == 3) ? 2 : 3, {30'h0, rx_enable, tx_enable});
		end
		$display("test auto done");
		tx_irq_raw <= 1'h1;
		rx_irq_raw <= 1'h1;
		for (int i = 0; i < 5; i++) begin
			wr(sfb_pkg::ADDR_FCNF, (i < 4) ? {28'h0, i[1:0], 2'h1} : 32'h0);
			repeat (2) @(posedge pclk);
			chk("irq", (i < 4) ? i[1:0] : 3, {30'h0, tx_irq, rx_irq});
		end
		$display("test irq done");
		give_verdict();
	end
endmodule
